//--- core/scp_config.sv
`timescale 1ns/100ps
// What this block does
// - bit 13 of the word picks channel 0 or 1 for a config write
// - short-detect-disable 1 stops short-to-supply detection; reset 0 keeps it
// - on-state open-load disable 1 suppresses on-state open-load detection
// - off-state open-load disable acts independently; both enabled by default
// - direct-control disable 0 follows direct input; 1 leaves PWM alone
// - two-bit slew code: 00 medium, 01 low, 10 high, 11 medium-high
// - three-bit delay postpones switch-on by that many PWM clock periods
// - high-range 0 forces highest low level; 1 lets low bit pick medium/lowest
// - no current-sense output while an overcurrent window is active
// - prescale bit divides external clock by 512 when 1, 256 when 0
// - clock-source 1 runs PWM from internal clock, 0 from external
// - sense-ratio 1 selects low-current ratio, 0 the high-current ratio
// - low-current ratio scales all overcurrent thresholds down by three
// - bulb uses high, middle, low thresholds in turn; motor only high, low
// - bulb window bits pick each window time; motor code picks one of four
// - upper threshold select 0 higher value, 1 lower value
// - middle select 0 higher, 1 lower; no effect in motor mode
// - after reset the load profile comes from the configuration pin
// - register addressed in one frame is returned in the following frame
module scp_config (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  // received serial word
  input  wire logic                      word_valid_i,
  input  wire logic [15:0]               word_i,
  // pins and channel status
  input  wire logic                      load_type_pin_i,
  input  wire logic [1:0]                direct_in_i,
  input  wire logic [1:0]                pwm_state_i,
  input  wire logic [1:0]                oc_window_active_i,
  // readback for the next frame
  output logic [8:0]                     readback_o,
  // detection enables per channel
  output logic [1:0]                     short_detect_en_o,
  output logic [1:0]                     on_openload_en_o,
  output logic [1:0]                     off_openload_en_o,
  // drive control per channel
  output logic [1:0]                     channel_on_o,
  output logic [3:0]                     slew_code_o,
  output logic [5:0]                     turn_on_delay_o,
  // pwm clock per channel
  output logic [1:0]                     pwm_clk_internal_o,
  output logic [19:0]                    ext_clk_divider_o,
  // overcurrent profile per channel
  output logic [1:0]                     load_is_motor_o,
  output logic [1:0]                     low_ratio_o,
  output logic [1:0]                     thresh_scale_third_o,
  output logic [3:0]                     window_time_code_o,
  output logic [1:0]                     upper_threshold_low_o,
  output logic [1:0]                     middle_threshold_low_o,
  output logic [1:0]                     middle_threshold_used_o,
  output logic [3:0]                     low_threshold_level_o,
  output logic [1:0]                     sense_output_en_o
);
  import scp_pkg::*;

  logic [8:0] load_type_pin_r [2];
  logic [8:0] ocp_r  [2];
  logic       load_pin_r;
  logic [8:0] readback_nxt;

  wire        bank_w  = word_i[BANK_BIT];
  wire  [2:0] addr_w  = word_i[ADDR_HI:ADDR_LO];
  wire  [8:0] data_w  = word_i[DATA_W-1:0];

  // register banks; the host owns bank choice per word, no broadcast write
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      load_type_pin_r[0] <= LOAD_TYPE_PIN_RST;
      load_type_pin_r[1] <= LOAD_TYPE_PIN_RST;
      ocp_r[0]  <= OCP_RST;
      ocp_r[1]  <= OCP_RST;
    end else if (word_valid_i) begin
      if (addr_w == ADDR_LOAD_TYPE_PIN) begin
        load_type_pin_r[bank_w] <= data_w;
      end
      if (addr_w == ADDR_OCP) begin
        ocp_r[bank_w] <= data_w;
      end
    end
  end

  // pin level caught by the clocked process, never inside the reset branch
  always_ff @(posedge clk_i) begin
    load_pin_r <= load_type_pin_i;
  end

  // a status word selects the register for the following frame
  always_comb begin
    readback_nxt = readback_o;
    if (word_valid_i && addr_w == ADDR_STAT) begin
      case (word_i[2:0])
        ADDR_LOAD_TYPE_PIN: readback_nxt = load_type_pin_r[bank_w];
        ADDR_OCP:  readback_nxt = ocp_r[bank_w];
        default:   readback_nxt = 9'h000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      readback_o <= 9'h000;
    end else begin
      readback_o <= readback_nxt;
    end
  end

  // per-channel decode, all outputs registered
  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire [8:0] cf = load_type_pin_r[c];
    wire [8:0] oc = ocp_r[c];
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        short_detect_en_o[c]       <= 1'b1;
        on_openload_en_o[c]        <= 1'b1;
        off_openload_en_o[c]       <= 1'b1;
        channel_on_o[c]            <= 1'b0;
        slew_code_o[2*c +: 2]      <= SCP_SLEW_MED;
        turn_on_delay_o[3*c +: 3]  <= 3'h0;
        pwm_clk_internal_o[c]      <= 1'b0;
        ext_clk_divider_o[10*c +: 10] <= DIV_SHORT;
        load_is_motor_o[c]         <= 1'b0;
        low_ratio_o[c]             <= 1'b0;
        thresh_scale_third_o[c]    <= 1'b0;
        window_time_code_o[2*c +: 2] <= 2'h0;
        upper_threshold_low_o[c]   <= 1'b0;
        middle_threshold_low_o[c]  <= 1'b0;
        middle_threshold_used_o[c] <= 1'b0;
        low_threshold_level_o[2*c +: 2] <= SCP_LOW_HIGHEST;
        sense_output_en_o[c]       <= 1'b0;
      end else begin
        short_detect_en_o[c]  <= ~cf[CF_SHORT_DIS];
        on_openload_en_o[c]   <= ~cf[CF_ONOL_DIS];
        off_openload_en_o[c]  <= ~cf[CF_OFFOL_DIS];
        channel_on_o[c]       <= cf[CF_DIR_DIS] ? pwm_state_i[c]
                                                 : direct_in_i[c];
        slew_code_o[2*c +: 2] <= cf[CF_SLEW_HI:CF_SLEW_LO];
        // the delay count itself is applied by the pwm engine in its clock periods
        turn_on_delay_o[3*c +: 3] <= cf[CF_DLY_HI:0];
        pwm_clk_internal_o[c] <= oc[OC_CLK_INT];
        ext_clk_divider_o[10*c +: 10] <= oc[OC_PRESCALE] ? DIV_LONG : DIV_SHORT;
        load_is_motor_o[c]    <= load_pin_r;
        low_ratio_o[c]        <= oc[OC_RATIO];
        thresh_scale_third_o[c] <= oc[OC_RATIO];
        // bulb: bits pick each window; motor: same two bits as one 4-way code
        window_time_code_o[2*c +: 2] <= {oc[OC_WIN1], oc[OC_WIN2]};
        upper_threshold_low_o[c] <= oc[OC_UPPER];
        middle_threshold_low_o[c] <= oc[OC_MIDDLE] & ~load_pin_r;
        middle_threshold_used_o[c] <= ~load_pin_r;
        if (!oc[OC_HIGH_RNG]) begin
          low_threshold_level_o[2*c +: 2] <= SCP_LOW_HIGHEST;
        end else if (oc[OC_LOW]) begin
          low_threshold_level_o[2*c +: 2] <= SCP_LOW_LOWEST;
        end else begin
          low_threshold_level_o[2*c +: 2] <= SCP_LOW_MEDIUM;
        end
        sense_output_en_o[c] <= ~oc_window_active_i[c];
      end
    end
  end
endmodule : scp_config

//--- common/scp_pkg.sv
package scp_pkg;
  // spi word layout
  localparam int          WORD_W       = 16;
  localparam int          BANK_BIT     = 13;
  localparam int          ADDR_HI      = 12;
  localparam int          ADDR_LO      = 10;
  localparam int          DATA_W       = 9;
  // register addresses (bits 12:10 of the word)
  localparam logic [2:0]  ADDR_STAT    = 3'h0;
  localparam logic [2:0]  ADDR_LOAD_TYPE_PIN    = 3'h2;
  localparam logic [2:0]  ADDR_OCP     = 3'h4;
  // channel configuration fields
  localparam int          CF_SHORT_DIS = 8;
  localparam int          CF_ONOL_DIS  = 7;
  localparam int          CF_OFFOL_DIS = 6;
  localparam int          CF_DIR_DIS   = 5;
  localparam int          CF_SLEW_HI   = 4;
  localparam int          CF_SLEW_LO   = 3;
  localparam int          CF_DLY_HI    = 2;
  // overcurrent configuration fields
  localparam int          OC_HIGH_RNG  = 8;
  localparam int          OC_PRESCALE  = 7;
  localparam int          OC_CLK_INT   = 6;
  localparam int          OC_RATIO     = 5;
  localparam int          OC_WIN1      = 4;
  localparam int          OC_WIN2      = 3;
  localparam int          OC_UPPER     = 2;
  localparam int          OC_MIDDLE    = 1;
  localparam int          OC_LOW       = 0;
  // reset values
  localparam logic [8:0]  LOAD_TYPE_PIN_RST     = 9'h000;
  localparam logic [8:0]  OCP_RST      = 9'h000;
  // external clock divider values
  localparam logic [9:0]  DIV_LONG     = 10'h200;
  localparam logic [9:0]  DIV_SHORT    = 10'h100;
  // slew codes
  typedef enum logic [1:0] {
    SCP_SLEW_MED  = 2'h0,
    SCP_SLEW_LOW  = 2'h1,
    SCP_SLEW_HIGH = 2'h2,
    SCP_SLEW_MHI  = 2'h3
  } scp_slew_t;
  // low threshold levels
  typedef enum logic [1:0] {
    SCP_LOW_HIGHEST = 2'h0,
    SCP_LOW_MEDIUM  = 2'h1,
    SCP_LOW_LOWEST  = 2'h2
  } scp_low_t;
endpackage : scp_pkg

//--- sim/scp_config_props.sv
`timescale 1ns/100ps
module scp_config_props
  import scp_pkg::*;
(
  // clock, reset and inputs
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        word_valid_i,
  input wire logic [15:0] word_i,
  input wire logic [1:0]  oc_window_active_i,
  // decoded outputs
  input wire logic [1:0]  short_detect_en_o,
  input wire logic [1:0]  on_openload_en_o,
  input wire logic [1:0]  off_openload_en_o,
  input wire logic [3:0]  slew_code_o,
  input wire logic [19:0] ext_clk_divider_o,
  input wire logic [1:0]  low_ratio_o,
  input wire logic [1:0]  thresh_scale_third_o,
  input wire logic [3:0]  low_threshold_level_o,
  input wire logic [1:0]  sense_output_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence load_type_pin_s(b); word_valid_i && word_i[13] == b && word_i[12:10] == ADDR_LOAD_TYPE_PIN; endsequence
  sequence ocp_s(b); word_valid_i && word_i[13] == b && word_i[12:10] == ADDR_OCP; endsequence
  short_en_a: assert property (load_type_pin_s(0) |-> ##2 short_detect_en_o[0] == !$past(word_i[8], 2))
    else $error("short detect enable wrong");
  openload_en_a: assert property (load_type_pin_s(1) |-> ##2 on_openload_en_o[1] == !$past(word_i[7], 2)
    && off_openload_en_o[1] == !$past(word_i[6], 2)) else $error("open-load enables wrong");
  slew_code_a: assert property (load_type_pin_s(0) |-> ##2 slew_code_o[1:0] == $past(word_i[4:3], 2))
    else $error("slew code wrong");
  bank_sel_a: assert property (load_type_pin_s(1) |-> ##2 slew_code_o[1:0] == $past(slew_code_o[1:0]))
    else $error("write leaked into other bank");
  ext_div_a: assert property (ocp_s(0) |-> ##2 ext_clk_divider_o[9:0] ==
    ($past(word_i[7], 2) ? DIV_LONG : DIV_SHORT)) else $error("divider wrong");
  scale_a: assert property (thresh_scale_third_o == low_ratio_o)
    else $error("threshold scaling differs from ratio");
  low_level_a: assert property (ocp_s(0) |-> ##2 low_threshold_level_o[1:0] ==
    (!$past(word_i[8], 2) ? 2'h0 : ($past(word_i[0], 2) ? 2'h2 : 2'h1))) else $error("low level");
  sense_a: assert property ($past(rst_b_i) |-> sense_output_en_o == ~$past(oc_window_active_i))
    else $error("sense output during window");
endmodule : scp_config_props
bind scp_config scp_config_props scp_config_props_inst (.clk_i, .rst_b_i, .word_valid_i, .word_i,
  .oc_window_active_i, .short_detect_en_o, .on_openload_en_o, .off_openload_en_o, .slew_code_o,
  .ext_clk_divider_o, .low_ratio_o, .thresh_scale_third_o, .low_threshold_level_o, .sense_output_en_o);

//--- sim/scp_host_model.sv
`timescale 1ns/100ps
module scp_host_model (
  // clock
  input  wire logic   clk_i,
  // word towards the block
  output logic        word_valid_o,
  output logic [15:0] word_o
);
  initial begin
    word_valid_o = 1'b0;
    word_o       = 16'h0000;
  end
  // one whole word per frame; the caller names the bank in every write
  task automatic send(input logic [15:0] wrd);
    @(posedge clk_i);
    #1 word_valid_o = 1'b1;
    word_o = wrd;
    @(posedge clk_i);
    #1 word_valid_o = 1'b0;
    // inverted after release so a stale word is never mistaken for fresh data
    word_o = ~wrd;
  endtask : send
endmodule : scp_host_model

//--- sim/tb_switch_channel_protection_config.sv
`timescale 1ns/100ps
module tb_switch_channel_protection_config;
  import scp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        pin = 1'b0;
  logic [1:0]  dir = 2'h0, pwm = 2'h0, win = 2'h0;
  logic        wv;
  logic [15:0] wd;
  logic [8:0]  rb;
  logic [1:0]  sh, onl, offl, con, pint, mot, mlo, mus, sen;
  logic [5:0]  dly;
  logic [3:0]  slw, wtc, lvl;
  logic [1:0]  upl, lrt, tsc;
  logic [19:0] div;
  int          errors = 0;
  int          num_checks = 0;
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
  always #2.5 clk_i = ~clk_i;
  scp_host_model scp_host_model_inst (.clk_i(clk_i), .word_valid_o(wv), .word_o(wd));
  scp_config scp_config_inst (.clk_i, .rst_b_i, .word_valid_i(wv), .word_i(wd),
    .load_type_pin_i(pin), .direct_in_i(dir), .pwm_state_i(pwm), .oc_window_active_i(win),
    .readback_o(rb), .short_detect_en_o(sh), .on_openload_en_o(onl), .off_openload_en_o(offl),
    .channel_on_o(con), .slew_code_o(slw), .turn_on_delay_o(dly), .pwm_clk_internal_o(pint),
    .ext_clk_divider_o(div), .load_is_motor_o(mot), .low_ratio_o(lrt),
    .thresh_scale_third_o(tsc),
    .window_time_code_o(wtc), .upper_threshold_low_o(upl), .middle_threshold_low_o(mlo),
    .middle_threshold_used_o(mus), .low_threshold_level_o(lvl), .sense_output_en_o(sen));
  function automatic logic [15:0] w(input logic b, input logic [2:0] a, input logic [8:0] d);
    return {2'h0, b, a, 1'b0, d};
  endfunction : w
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic t_reset;
    `CHK("enables", 6'h3F, {sh, onl, offl})
    `CHK("readback", 9'h000, rb)
  endtask : t_reset
  task automatic t_load_type_pin;
    dir = 2'h1;
    pwm = 2'h2;
    scp_host_model_inst.send(w(1'b1, ADDR_LOAD_TYPE_PIN, 9'h1AD));
    scp_host_model_inst.send(w(1'b0, 3'h7, 9'h1FF));
    step(1);
    `CHK("detect", 6'h17, {sh, onl, offl})
    `CHK("slew", 4'h4, slw)
    `CHK("delay", 6'h28, dly)
    `CHK("drive", 2'h3, con)
    scp_host_model_inst.send(w(1'b1, ADDR_STAT, 9'h002));
    step(1);
    `CHK("readback ch1", 9'h1AD, rb)
    scp_host_model_inst.send(w(1'b0, ADDR_STAT, 9'h002));
    step(1);
    `CHK("readback ch0", 9'h000, rb)
  endtask : t_load_type_pin
  task automatic t_ocp;
    for (int i = 0; i < 4; i++) begin
      scp_host_model_inst.send(w(1'b0, ADDR_OCP, {i[1], 6'h35, 1'b1, i[0]}));
      step(1);
      `CHK("low level", (i[1] ? (i[0] ? 2'h2 : 2'h1) : 2'h0), lvl[1:0])
    end
    `CHK("clock source", 1'b1, pint[0])
    `CHK("window code", 2'h2, wtc[1:0])
    `CHK("middle bulb", 1'b1, mlo[0])
    `CHK("upper low", 1'b1, upl[0])
    `CHK("divider long", DIV_LONG, div[9:0])
    `CHK("ratio high", 2'h0, lrt)
  endtask : t_ocp
  task automatic t_pin;
    pin = 1'b1;
    win = 2'h2;
    step(3);
    `CHK("motor", 2'h3, mot)
    `CHK("middle motor", 3'h0, {mlo[0], mus})
    `CHK("sense", 2'h1, sen)
    scp_host_model_inst.send(w(1'b0, ADDR_OCP, 9'h020));
    step(1);
    `CHK("ratio low", 2'h1, lrt)
    `CHK("scale third", 2'h1, tsc)
    `CHK("divider short", DIV_SHORT, div[9:0])
    `CHK("upper high", 1'b0, upl[0])
  endtask : t_pin
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    t_reset();
    t_load_type_pin();
    t_ocp();
    t_pin();
    test_done();
  end
  // the run is short; this only cuts a hang
  initial begin
    #50000;
    errors++;
    test_done();
  end
endmodule : tb_switch_channel_protection_config
